// ### logic/pci_wide_burst_reader.sv
// bus master data phases for 64-bit burst reads toward a 64-bit local master
`timescale 1ns/1ps

// Notes on behaviour
// R1: load burst counter with requested length
// R2: local master gives first byte enables early
// R3: local read-ready only when data acceptable
// R4: drop reqn after framen without local request
// R5: target claims with devseln and ack64n
// R6: turnaround: float ad, drive byte enables
// R7: irdyn follows local read-ready one cycle later
// R8: framen held while phases remain
// R9: wide flag asserted once target accepts
// R10: local grant follows gntn once started
// R11: target drives quadwords with trdyn
// R12: phase completes when irdyn and trdyn low
// R13: next cycle: output quadword, decrement counter
// R14: strobes after trdyn and read-ready both low
// R15: local master captures on both strobes
// R16: local master keeps read-ready to avoid waits
// R17: final phase drops framen and req64n
// R18: afterwards irdyn high, normal termination reported
// R19: local master requests with wide request
// R20: phase reaching zero count is last
module pci_wide_burst_reader
  import pci_rd_pkg::*;
#(
  parameter int BURST_W = pci_rd_pkg::BURST_W_DEF
) (
  // clock and reset
  input  wire logic                         ref_clk_in,
  input  wire logic                         arst_n_in,
  // pci inputs
  input  wire logic                         gntn_in,
  input  wire logic                         framen_in,
  input  wire logic                         irdyn_in,
  input  wire logic                         devseln_in,
  input  wire logic                         ack64n_in,
  input  wire logic                         trdyn_in,
  input  wire logic [pci_rd_pkg::AD_W-1:0]  ad_in,
  // pci outputs
  output logic                              reqn_out,
  output logic      [pci_rd_pkg::AD_W-1:0]  ad_out,
  output pci_rd_pkg::pci_drive_s            pci_drive_out,
  output pci_rd_pkg::pci_enable_s           pci_enable_out,
  // local master inputs
  input  wire logic                         local_wide_request_n_in,
  input  wire logic [pci_rd_pkg::ADDR_W-1:0] local_address_in,
  input  wire logic [pci_rd_pkg::CMD_W-1:0] local_command_in,
  input  wire logic [BURST_W-1:0]           local_requested_burst_length_in,
  input  wire logic [pci_rd_pkg::CBE_W-1:0] local_byte_enable_in,
  input  wire logic                         local_read_ready_n_in,
  // local master outputs
  output logic                              local_grant_n_out,
  output logic                              local_wide_transfer_flag_n_out,
  output logic                              local_low_half_strobe_n_out,
  output logic                              local_high_half_strobe_n_out,
  output logic      [pci_rd_pkg::AD_W-1:0]  local_read_data_out,
  output logic      [BURST_W-1:0]           local_burst_remaining_count_out,
  output logic      [pci_rd_pkg::CODE_W-1:0] local_master_state_code_out,
  output logic      [pci_rd_pkg::END_W-1:0] local_end_reason_code_out
);

  import pci_rd_pkg::*;

  if (BURST_W < 2) begin : g_burst_check
    $error("burst length width must be at least two bits");
  end

  localparam logic [BURST_W-1:0] LEN_ONE = {{(BURST_W-1){1'b0}}, 1'b1};

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  master_state_e          state_reg;
  master_state_e          state_next;
  logic                   reqn_reg;
  logic                   reqn_next;
  logic                   grant_n_reg;
  logic                   grant_n_next;
  logic                   wide_n_reg;
  logic                   wide_n_next;
  logic                   xfer_n_reg;
  logic                   xfer_n_next;
  logic [AD_W-1:0]        data_reg;
  logic [AD_W-1:0]        ad_reg;
  logic [AD_W-1:0]        ad_next;
  logic [CODE_W-1:0]      code_reg;
  logic [CODE_W-1:0]      code_next;
  logic [END_W-1:0]       end_reg;
  logic [END_W-1:0]       end_next;
  pci_drive_s             drive_reg;
  pci_drive_s             drive_next;
  pci_enable_s            enable_reg;
  pci_enable_s            enable_next;

  logic [BURST_W-1:0]     count;
  logic [BURST_W-1:0]     len_load;
  logic                   cnt_last;
  logic                   cnt_two;
  logic                   bus_idle;
  logic                   grant_ok;
  logic                   phase_done;
  logic                   final_done;
  logic                   final_next;
  logic                   claimed;
  logic                   started;
  logic                   ns_frame;
  logic                   ns_irdy;
  logic                   load_go;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  assign bus_idle = framen_in && irdyn_in;
  assign grant_ok = !gntn_in && bus_idle && !reqn_reg;
  // R12: both ready strobes low
  assign phase_done = (state_reg == ST_DATA) && !drive_reg.irdyn &&
                      !trdyn_in;
  // R20: counter reaching zero ends burst
  assign final_done = phase_done && cnt_last;
  assign final_next = cnt_last || (cnt_two && phase_done);
  // R5: target claims wide transfer
  assign claimed  = ((state_reg == ST_TURN) || (state_reg == ST_DATA)) &&
                    !devseln_in && !ack64n_in;
  assign started  = (state_reg == ST_ADDRESS) || (state_reg == ST_TURN) ||
                    (state_reg == ST_DATA);
  assign ns_frame = (state_next == ST_ADDRESS) || (state_next == ST_TURN) ||
                    (state_next == ST_DATA);
  assign ns_irdy  = (state_next == ST_TURN) || (state_next == ST_DATA);
  assign load_go  = (state_reg == ST_LOAD) && (state_next == ST_ADDRESS);
  // zero length treated as a single phase
  assign len_load = (local_requested_burst_length_in == '0) ? LEN_ONE :
                    local_requested_burst_length_in;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (grant_ok) begin
          state_next = ST_GRANTED;
        end
      end
      ST_GRANTED: begin
        state_next = local_wide_request_n_in ? ST_IDLE : ST_LOAD;
      end
      ST_LOAD: begin
        state_next = gntn_in ? ST_IDLE : ST_ADDRESS;
      end
      ST_ADDRESS: state_next = ST_TURN;
      ST_TURN:    state_next = ST_DATA;
      ST_DATA: begin
        if (final_done) begin
          state_next = ST_TERM;
        end
      end
      ST_TERM:    state_next = ST_IDLE;
      default:    state_next = ST_IDLE;
    endcase
  end

  // R4: release request once frame seen alone
  assign reqn_next = (state_reg == ST_IDLE) ? local_wide_request_n_in :
                     (!drive_reg.framen && enable_reg.framen &&
                      local_wide_request_n_in) ? 1'b1 : reqn_reg;
  // R10: grant tracks gntn after start
  assign grant_n_next = ((state_next == ST_GRANTED) ||
                         (state_next == ST_LOAD) ||
                         (state_next == ST_ADDRESS)) ? 1'b0 :
                        started ? gntn_in : 1'b1;
  // R9: wide flag once claimed
  assign wide_n_next = (state_next == ST_IDLE) ? 1'b1 :
                       claimed ? 1'b0 : wide_n_reg;
  // R14: strobes from trdyn and read-ready
  assign xfer_n_next = !((state_reg == ST_DATA) && !trdyn_in &&
                         !local_read_ready_n_in);
  assign ad_next = (state_next == ST_ADDRESS) ?
                   {AD_HIGH_ZERO, local_address_in} : ad_reg;
  assign code_next = (state_next == ST_LOAD) ? CODE_ADDR_LOAD :
                     (state_next == ST_TERM) ? CODE_BUS_TERM :
                     ns_frame ? CODE_BUS_TRANS : CODE_IDLE;
  // R18: normal end reported with termination
  assign end_next = (state_next == ST_TERM) ? END_NORMAL :
                    (state_next == ST_LOAD) ? END_NONE : end_reg;

  // R8: frame held until final phase
  // R17: frame and req64n drop on final phase
  assign drive_next.framen = (state_next == ST_ADDRESS) ? 1'b0 :
                             ns_frame ? final_next : 1'b1;
  assign drive_next.req64n = drive_next.framen;
  // R7: irdyn mirrors earlier read-ready
  assign drive_next.irdyn  = ns_irdy ? local_read_ready_n_in : 1'b1;
  // R2: byte enables sampled a cycle ahead
  assign drive_next.cben   = (state_next == ST_ADDRESS) ?
                             {CBE_HIGH_ZERO, local_command_in} :
                             local_byte_enable_in;
  // R6: ad floats after address phase
  assign enable_next.ad     = (state_next == ST_ADDRESS);
  assign enable_next.framen = ns_frame;
  assign enable_next.req64n = ns_frame;
  assign enable_next.cben   = ns_frame;
  assign enable_next.irdyn  = ns_irdy || (state_next == ST_TERM);

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg   <= ST_IDLE;
      reqn_reg    <= 1'b1;
      grant_n_reg <= 1'b1;
      wide_n_reg  <= 1'b1;
      xfer_n_reg  <= 1'b1;
      code_reg    <= CODE_IDLE;
      end_reg     <= END_NONE;
      drive_reg   <= DRIVE_IDLE;
      enable_reg  <= ENABLE_NONE;
      ad_reg      <= '0;
    end else begin
      state_reg   <= state_next;
      reqn_reg    <= reqn_next;
      grant_n_reg <= grant_n_next;
      wide_n_reg  <= wide_n_next;
      xfer_n_reg  <= xfer_n_next;
      code_reg    <= code_next;
      end_reg     <= end_next;
      drive_reg   <= drive_next;
      enable_reg  <= enable_next;
      ad_reg      <= ad_next;
    end
  end

  // R13: quadword captured on completed phase
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      data_reg <= '0;
    end else if (phase_done) begin
      data_reg <= ad_in;
    end
  end

  // R1: counter loaded as address phase starts
  burst_phase_counter #(
    .W (BURST_W)
  ) u_counter (
    .ref_clk_in    (ref_clk_in),
    .arst_n_in     (arst_n_in),
    .load_in       (load_go),
    .load_value_in (len_load),
    .dec_in        (phase_done),
    .count_out     (count),
    .last_out      (cnt_last),
    .second_out    (cnt_two)
  );

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign reqn_out                        = reqn_reg;
  assign ad_out                          = ad_reg;
  assign pci_drive_out                   = drive_reg;
  assign pci_enable_out                  = enable_reg;
  assign local_grant_n_out               = grant_n_reg;
  assign local_wide_transfer_flag_n_out  = wide_n_reg;
  assign local_low_half_strobe_n_out     = xfer_n_reg;
  assign local_high_half_strobe_n_out    = xfer_n_reg;
  assign local_read_data_out             = data_reg;
  assign local_burst_remaining_count_out = count;
  assign local_master_state_code_out     = code_reg;
  assign local_end_reason_code_out       = end_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);

  property p_load;
    load_go |=> (count == $past(len_load));
  endproperty
  a_load: assert property (p_load) // R1
    else $error("burst counter not loaded");

  property p_reqn_drop;
    (state_reg != ST_IDLE && enable_reg.framen && !drive_reg.framen &&
     local_wide_request_n_in) |=> reqn_out;
  endproperty
  a_reqn_drop: assert property (p_reqn_drop) // R4
    else $error("reqn not released");

  property p_turn;
    (state_reg == ST_TURN) |-> (!pci_enable_out.ad && pci_enable_out.cben &&
      pci_drive_out.cben == $past(local_byte_enable_in));
  endproperty
  a_turn: assert property (p_turn) // R6
    else $error("turnaround drive wrong");

  property p_irdy;
    (ns_irdy && !local_read_ready_n_in) |=>
      (!pci_drive_out.irdyn && pci_enable_out.irdyn);
  endproperty
  a_irdy: assert property (p_irdy) // R7
    else $error("irdyn not following read-ready");

  property p_frame_hold;
    (state_reg == ST_DATA && count > 3) |-> !pci_drive_out.framen;
  endproperty
  a_frame_hold: assert property (p_frame_hold) // R8
    else $error("framen dropped early");

  property p_wide;
    claimed |=> !local_wide_transfer_flag_n_out;
  endproperty
  a_wide: assert property (p_wide) // R9
    else $error("wide flag missing");

  property p_grant;
    started |=> (local_grant_n_out == $past(gntn_in));
  endproperty
  a_grant: assert property (p_grant) // R10
    else $error("local grant not following gntn");

  property p_data;
    phase_done |=> (local_read_data_out == $past(ad_in) &&
                    count == $past(count) - LEN_ONE);
  endproperty
  a_data: assert property (p_data) // R13
    else $error("quadword or count not updated");

  property p_strobe;
    (state_reg == ST_DATA && !trdyn_in && !local_read_ready_n_in) |=>
      (!local_low_half_strobe_n_out && !local_high_half_strobe_n_out);
  endproperty
  a_strobe: assert property (p_strobe) // R14
    else $error("transfer strobes missing");

  property p_last_frame;
    (state_reg == ST_DATA && cnt_last) |->
      (pci_drive_out.framen && pci_drive_out.req64n);
  endproperty
  a_last_frame: assert property (p_last_frame) // R17
    else $error("framen held on final phase");

  property p_term;
    final_done |=> (pci_drive_out.irdyn && !pci_enable_out.framen &&
      local_master_state_code_out == CODE_BUS_TERM &&
      local_end_reason_code_out == END_NORMAL && count == '0)
      ##1 (!pci_enable_out.irdyn);
  endproperty
  a_term: assert property (p_term) // R18
    else $error("termination sequence wrong");

  c_single: cover property (load_go && len_load == LEN_ONE ##[1:20] final_done);
  c_burst: cover property (phase_done ##1 phase_done ##1 phase_done);
  c_wait: cover property ((state_reg == ST_DATA) && pci_drive_out.irdyn);
  c_lost_grant: cover property ((state_reg == ST_LOAD) && gntn_in);

endmodule

// ### logic/pci_rd_pkg.sv
// shared constants, state codes and pin carriers for the wide burst reader
package pci_rd_pkg;

  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int AD_W        = 64;
  localparam int CBE_W       = 8;
  localparam int CMD_W       = 4;
  localparam int ADDR_W      = 32;
  localparam int BURST_W_DEF = 8;
  localparam int CODE_W      = 4;
  localparam int END_W       = 3;

  // ----------------------------------------------------------------------
  // local status codes
  // ----------------------------------------------------------------------
  localparam logic [CODE_W-1:0] CODE_IDLE      = 4'h0;
  localparam logic [CODE_W-1:0] CODE_ADDR_LOAD = 4'h1;
  localparam logic [CODE_W-1:0] CODE_BUS_TRANS = 4'h2;
  localparam logic [CODE_W-1:0] CODE_BUS_TERM  = 4'h3;
  localparam logic [END_W-1:0]  END_NONE       = 3'h0;
  localparam logic [END_W-1:0]  END_NORMAL     = 3'h1;

  // padding for address and command onto the wide pins
  localparam logic [AD_W-ADDR_W-1:0] AD_HIGH_ZERO = 32'h0;
  localparam logic [CBE_W-CMD_W-1:0] CBE_HIGH_ZERO = 4'h0;

  // ----------------------------------------------------------------------
  // master sequence states
  // ----------------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_GRANTED = 7'h02,
    ST_LOAD    = 7'h04,
    ST_ADDRESS = 7'h08,
    ST_TURN    = 7'h10,
    ST_DATA    = 7'h20,
    ST_TERM    = 7'h40
  } master_state_e;

  // ----------------------------------------------------------------------
  // pin carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic             framen;
    logic             req64n;
    logic             irdyn;
    logic [CBE_W-1:0] cben;
  } pci_drive_s;

  typedef struct packed {
    logic framen;
    logic req64n;
    logic irdyn;
    logic cben;
    logic ad;
  } pci_enable_s;

  localparam pci_drive_s  DRIVE_IDLE  = '{1'b1, 1'b1, 1'b1, 8'hff};
  localparam pci_enable_s ENABLE_NONE = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

endpackage

// ### logic/burst_phase_counter.sv
// down-counter of remaining quadword data phases
`timescale 1ns/1ps
module burst_phase_counter #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         ref_clk_in,
  input  wire logic         arst_n_in,
  // control
  input  wire logic         load_in,
  input  wire logic [W-1:0] load_value_in,
  input  wire logic         dec_in,
  // state
  output logic      [W-1:0] count_out,
  output logic              last_out,
  output logic              second_out
);

  localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};
  localparam logic [W-1:0] TWO = {{(W-2){1'b0}}, 2'b10};

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  if (W < 2) begin : g_width_check
    $error("counter width must be at least two bits");
  end

  // load wins; decrement never wraps below zero
  assign count_next = load_in ? load_value_in :
                      (dec_in && count_reg != '0) ? count_reg - ONE :
                      count_reg;

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count_out  = count_reg;
  assign last_out   = (count_reg == ONE);
  assign second_out = (count_reg == TWO);

endmodule

// ### test/pci_target_model.sv
// behavioural pci target answering wide burst reads
`timescale 1ns/1ps
module pci_target_model #(
  parameter logic [63:0] DATA_BASE = 64'h0123_4567_89ab_0000
) (
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        arst_n_in,
  // resolved bus lines and pacing
  input  wire logic        framen_in,
  input  wire logic        irdyn_in,
  input  wire logic [3:0]  wait_in,
  // target drive
  output logic             devseln_out,
  output logic             ack64n_out,
  output logic             trdyn_out,
  output logic      [63:0] ad_out
);
  logic       claimed_reg;
  logic [3:0] wait_reg;
  logic [7:0] index_reg;
  wire        phase_done;

  // ----------------------------------------
  // phase tracking
  // ----------------------------------------
  // both ready lines low
  assign phase_done = claimed_reg & ~irdyn_in & ~trdyn_out;

  // undriven ad toggles so stale data never looks valid
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      claimed_reg <= 1'b0;
      wait_reg    <= 4'h0;
      index_reg   <= 8'h00;
      devseln_out <= 1'b1;
      ack64n_out  <= 1'b1;
      trdyn_out   <= 1'b1;
      ad_out      <= 64'h0;
    end else if (!claimed_reg) begin
      ad_out <= ~ad_out;
      if (!framen_in) begin
        claimed_reg <= 1'b1;
        devseln_out <= 1'b0;
        ack64n_out  <= 1'b0;
        wait_reg    <= wait_in;
        index_reg   <= 8'h00;
      end
    end else if (phase_done && framen_in) begin
      claimed_reg <= 1'b0;
      devseln_out <= 1'b1;
      ack64n_out  <= 1'b1;
      trdyn_out   <= 1'b1;
      ad_out      <= ~ad_out;
    end else if (phase_done) begin
      index_reg <= index_reg + 8'h01;
      if (wait_in == 4'h0) begin
        ad_out <= DATA_BASE + {56'h0, index_reg + 8'h01};
      end else begin
        trdyn_out <= 1'b1;
        wait_reg  <= wait_in - 4'h1;
        ad_out    <= ~ad_out;
      end
    end else if (trdyn_out) begin
      if (wait_reg == 4'h0) begin
        trdyn_out <= 1'b0;
        ad_out    <= DATA_BASE + {56'h0, index_reg};
      end else begin
        wait_reg <= wait_reg - 4'h1;
        ad_out   <= ~ad_out;
      end
    end
  end
endmodule

// ### test/testbench.sv
// self-checking bench for the wide burst reader
`timescale 1ns/1ps
module testbench;
  import pci_rd_pkg::*;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam logic [63:0] BASE = 64'h0123_4567_89ab_0000;
  typedef struct packed {
    logic [7:0] len;
    logic [3:0] wt;
    logic [3:0] stall;
    logic [7:0] be;
    logic [7:0] phases;
  } row_s;
  logic        ref_clk, arst_n, gnt_n, wide_req_n, ready_n;
  logic [3:0]  wait_c;
  logic [7:0]  len_v, be_v, count;
  logic        devseln, ack64n, trdyn, reqn, grant_n, flag_n, lo_n, hi_n;
  logic [63:0] t_ad, dut_ad, rdata;
  logic [3:0]  code;
  logic [2:0]  endc;
  pci_drive_s  drive;
  pci_enable_s en;
  wire         frame_w = en.framen ? drive.framen : 1'b1;
  wire         irdy_w  = en.irdyn ? drive.irdyn : 1'b1;
  wire [63:0]  ad_w    = en.ad ? dut_ad : t_ad;
  int          n_fail, n_checks, cycles;
  // len, wait, stall, byte enables, expected phases
  row_s rows [6] = '{
    '{8'h03, 4'h0, 4'h0, 8'hff, 8'h03}, '{8'h01, 4'h0, 4'h0, 8'h0f, 8'h01},
    '{8'h02, 4'h2, 4'h0, 8'hf0, 8'h02}, '{8'h04, 4'h3, 4'h2, 8'h5a, 8'h04},
    '{8'h00, 4'h0, 4'h0, 8'ha5, 8'h01}, '{8'hff, 4'h0, 4'h0, 8'h3c, 8'hff}};

  pci_wide_burst_reader #(.BURST_W(8)) pci_wide_burst_reader_i (
    .ref_clk_in(ref_clk), .arst_n_in(arst_n), .gntn_in(gnt_n),
    .framen_in(frame_w), .irdyn_in(irdy_w), .devseln_in(devseln),
    .ack64n_in(ack64n), .trdyn_in(trdyn), .ad_in(ad_w), .reqn_out(reqn),
    .ad_out(dut_ad), .pci_drive_out(drive), .pci_enable_out(en),
    .local_wide_request_n_in(wide_req_n),
    .local_address_in(32'h8000_0100), .local_command_in(4'h6),
    .local_requested_burst_length_in(len_v), .local_byte_enable_in(be_v),
    .local_read_ready_n_in(ready_n), .local_grant_n_out(grant_n),
    .local_wide_transfer_flag_n_out(flag_n),
    .local_low_half_strobe_n_out(lo_n), .local_high_half_strobe_n_out(hi_n),
    .local_read_data_out(rdata), .local_burst_remaining_count_out(count),
    .local_master_state_code_out(code), .local_end_reason_code_out(endc));

  pci_target_model #(.DATA_BASE(BASE)) pci_target_model_i (
    .ref_clk_in(ref_clk), .arst_n_in(arst_n), .framen_in(frame_w),
    .irdyn_in(irdy_w), .wait_in(wait_c), .devseln_out(devseln),
    .ack64n_out(ack64n), .trdyn_out(trdyn), .ad_out(t_ad));

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk_flag(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: flag %b want %b", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %h want %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check_reset();
    chk_flag(reqn, 1'b1);
    chk_flag(grant_n & flag_n & lo_n & hi_n, 1'b1);
    chk_val({code, endc}, {CODE_IDLE, END_NONE});
    chk_val(en, ENABLE_NONE);
    chk_val(drive, DRIVE_IDLE);
    chk_val(count, 64'h0);
    chk_val(rdata, 64'h0);
    chk_val(dut_ad, 64'h0);
  endtask

  // ----------------------------------------
  // one burst read as the local master
  // ----------------------------------------
  task automatic run_txn(input row_s r);
    int k, t, stall;
    logic done;
    k = 0;
    t = 0;
    done = 1'b0;
    stall = r.stall;
    wait_c = r.wt;
    len_v = r.len;
    be_v = r.be;
    ready_n = (stall == 0) ? 1'b0 : 1'b1;
    wide_req_n = 1'b0;
    while (reqn !== 1'b0 && t < 9) begin
      @(negedge ref_clk);
      t++;
    end
    gnt_n = 1'b0;
    while (code !== CODE_BUS_TRANS && t < 30) begin
      @(negedge ref_clk);
      t++;
    end
    chk_val(count, r.phases);
    chk_flag(grant_n, 1'b0);
    chk_flag(en.ad, 1'b1);
    chk_val(dut_ad, 64'h8000_0100);
    wide_req_n = 1'b1;
    gnt_n = 1'b1;
    @(negedge ref_clk);
    chk_flag(reqn, 1'b1);
    chk_flag(en.ad, 1'b0);
    chk_val({en.cben, drive.cben}, {1'b1, r.be});
    while (!done && t < 600) begin
      if (lo_n === 1'b0) begin
        k++;
        chk_flag(hi_n, 1'b0);
        chk_val(rdata, BASE + k - 1);
        chk_val(count, r.phases - k);
        chk_flag(flag_n, 1'b0);
      end
      if (code === CODE_BUS_TERM) begin
        chk_val(endc, END_NORMAL);
        chk_flag(drive.irdyn & en.irdyn, 1'b1);
        chk_val(count, 64'h0);
        done = 1'b1;
      end else begin
        chk_flag(drive.irdyn, ready_n);
        chk_flag(grant_n, 1'b1);
        if (count > 8'h02) chk_flag(drive.framen, 1'b0);
        if (count == 8'h01) chk_flag(drive.framen & drive.req64n, 1'b1);
      end
      if (stall != 0) begin
        stall--;
        if (stall == 0) ready_n = 1'b0;
      end
      @(negedge ref_clk);
      t++;
    end
    chk_flag(done, 1'b1);
    chk_val(k, r.phases);
    chk_val({code, flag_n}, {CODE_IDLE, 1'b1});
    ready_n = 1'b1;
    // let an edge pass so the next request never lands in this step
    @(negedge ref_clk);
  endtask

  // ----------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // no test here needs more than a few hundred cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    {arst_n, wait_c, len_v, be_v} = '0;
    {gnt_n, wide_req_n, ready_n} = 3'h7;
    repeat (20) @(negedge ref_clk);
    check_reset();
    arst_n = 1'b1;
    @(negedge ref_clk);
    foreach (rows[i]) run_txn(rows[i]);
    // grant withdrawn while loading: no bus cycle may follow
    wide_req_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    gnt_n = 1'b0;
    while (code !== CODE_ADDR_LOAD && cycles < 4000) @(negedge ref_clk);
    chk_flag(grant_n, 1'b0);
    gnt_n = 1'b1;
    @(negedge ref_clk);
    chk_val({code, en.framen, grant_n}, {CODE_IDLE, 2'b01});
    wide_req_n = 1'b1;
    @(negedge ref_clk);
    // reset in mid-burst must drop every output at once
    len_v = 8'h10;
    wide_req_n = 1'b0;
    ready_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    gnt_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    {arst_n, wide_req_n, gnt_n} = 3'h3;
    @(negedge ref_clk);
    check_reset();
    arst_n = 1'b1;
    @(negedge ref_clk);
    run_txn(rows[0]);
    print_verdict();
  end
endmodule
